// File: include/cw_test_pkg.sv
/*
 * Package for the continuous transmit test block: register offsets, field
 * layouts, reset values, modes, states and carrier structs.
 * Assumes a 250 MHz single clock and an Avalon-MM register slave.
 */
package cont_tx_pkg;

	// register byte addresses (one aligned 32-bit word each, except the buffer: one octet per byte address from 0x80)
	localparam logic [7:0] ADDR_STATE_CMD   = 8'h08; // index 0x02
	localparam logic [7:0] ADDR_MODE        = 8'h00;
	localparam logic [7:0] ADDR_STATUS      = 8'h04;
	localparam logic [7:0] ADDR_BUF_BASE    = 8'h80;
	localparam logic [7:0] ADDR_BUF_MASK    = 8'h80;

	// command field in the state/command register, low five bits
	localparam int         CMD_LSB          = 0;
	localparam int         CMD_W            = 5;
	localparam logic [4:0] CMD_NOP          = 5'h00;
	localparam logic [4:0] CMD_TX_START     = 5'h02;
	localparam logic [4:0] CMD_RADIO_OFF    = 5'h08;
	localparam logic [4:0] CMD_SYNTH_ON     = 5'h09;

	// mode register fields
	localparam int         MODE_SEL_BIT     = 0;
	localparam int         TONE_SEL_LSB     = 1;
	localparam logic [1:0] TONE_MINUS_2M    = 2'h0;
	localparam logic [1:0] TONE_PLUS_HALF   = 2'h1;
	localparam logic [1:0] TONE_MINUS_HALF  = 2'h2;

	// transceiver state codes seen in the status register
	localparam logic [4:0] ST_CODE_OFF      = 5'h08;
	localparam logic [4:0] ST_CODE_SYNTH    = 5'h09;
	localparam logic [4:0] ST_CODE_TX       = 5'h02;

	// reset value and length limit
	localparam logic [2:0] MODE_RST         = 3'h0;
	localparam logic [7:0] LEN_MAX          = 8'h7F;

	// sizes
	localparam int         BUF_DEPTH        = 128;
	localparam int         BUF_AW           = 7;
	localparam int         FIFO_W           = 8;
	localparam int         FIFO_D           = 16;

	// tone offsets in kHz, signed, as reported on the tone output
	localparam logic signed [11:0] OFS_MINUS_2M   = -12'sd2000;
	localparam logic signed [11:0] OFS_PLUS_HALF  = 12'sd500;
	localparam logic signed [11:0] OFS_MINUS_HALF = -12'sd500;

	typedef enum logic [1:0] {SEL_PSEUDO, SEL_TONE} tx_sel_e;

	typedef enum {
		RADIO_OFF,
		SYNTH_ON,
		EMITTING
	} radio_state_e;

	// radio front-end control bundle
	typedef struct packed {
		logic       tone_on;
		logic signed [11:0] offset_khz;
		logic       carrier_on;
	} rf_ctrl_s;

endpackage

// File: rtl/octet_fifo.sv
/*
 * Synchronous FIFO, width and depth as parameters, valid/ready both sides,
 * and the frame buffer store with its registered read port.
 * Assumes one clock, synchronous active-high reset and a clock enable.
 */
module octet_fifo
	import cont_tx_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             clk_en_i,
	input  wire logic             flush_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
	assign out_valid_o = (count_r != '0);
	assign out_data_o  = mem_r[rd_ptr_r];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge mclk_i)
	begin
		if (clk_en_i && push)
			mem_r[wr_ptr_r] <= in_data_i;
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || (clk_en_i && flush_i))
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else if (clk_en_i)
		begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end

	// fill/drain bookkeeping must never exceed the depth
	property p_fifo_bound;
		@(posedge mclk_i) disable iff (sys_rst_i)
		count_r <= (AW+1)'(DEPTH);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound)
		else $error("fifo count above depth");

endmodule

// read word holds while re_i is low, so a refused octet can wait here
module frame_mem
	import cont_tx_pkg::*;
(
	// clock
	input  wire logic              mclk_i,
	// write port
	input  wire logic              we_i,
	input  wire logic [BUF_AW-1:0] waddr_i,
	input  wire logic [7:0]        wdata_i,
	// read port
	input  wire logic              re_i,
	input  wire logic [BUF_AW-1:0] raddr_i,
	output logic      [7:0]        rdata_o
);
	logic [7:0] mem_r [BUF_DEPTH];

	always_ff @(posedge mclk_i)
	begin
		if (we_i)
			mem_r[waddr_i] <= wdata_i;
	end

	always_ff @(posedge mclk_i)
	begin
		if (re_i)
			rdata_o <= mem_r[raddr_i];
	end
endmodule

// File: rtl/cont_tx_test.sv
/*
 * Continuous transmit test block: frame buffer, state command register,
 * pseudo-random data streaming and tone control, Avalon-MM register slave.
 * Assumes test_mode_pin arrives asynchronously from a pin; the modulator
 * consumes octets through valid/ready.
 */
module cont_tx_test
	import cont_tx_pkg::*;
(
	// clock, reset, enable
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        clk_en_i,
	// test pin
	input  wire logic        test_mode_pin_i,
	// avalon-mm slave
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// modulator side
	output logic      [7:0]  tx_octet_o,
	output logic             tx_valid_o,
	input  wire logic        tx_ready_i,
	output rf_ctrl_s         rf_ctrl_o
);

	logic                 pin_s1_r;
	logic                 pin_s2_r;
	logic                 test_en;
	radio_state_e         state_r;
	logic [2:0]           mode_r;
	logic [7:0]           len_r;
	logic [BUF_AW-1:0]    rd_idx_r;
	logic                 rd_pend_r;
	logic [7:0]           rd_data;
	logic                 acc_done_r;
	logic [31:0]          rdata_r;
	logic                 fifo_in_ready;
	logic                 fifo_out_valid;
	logic [7:0]           fifo_out_data;
	logic                 out_valid_r;
	logic [7:0]           out_octet_r;
	rf_ctrl_s             rf_r;
	logic                 emitting;
	logic                 pseudo_sel;
	logic                 buf_we;
	logic                 cmd_we;
	logic                 fetch;
	logic [4:0]           cmd;

	function automatic logic is_buf(input logic [7:0] a);
		return (a & ADDR_BUF_MASK) == ADDR_BUF_BASE;
	endfunction

	function automatic logic signed [11:0] tone_ofs(input logic [1:0] s);
		unique case (s)
			TONE_MINUS_2M:   return OFS_MINUS_2M;
			TONE_PLUS_HALF:  return OFS_PLUS_HALF;
			default:         return OFS_MINUS_HALF;
		endcase
	endfunction

	// pin from outside the clock domain: two stages before any use
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
		end
		else if (clk_en_i)
		begin
			pin_s1_r <= test_mode_pin_i;
			pin_s2_r <= pin_s1_r;
		end
	end
	assign test_en    = pin_s2_r;
	assign emitting   = (state_r == EMITTING);
	assign pseudo_sel = (mode_r[MODE_SEL_BIT] == 1'b0);

	// bus access: one wait state, then a single-cycle answer
	// writes land on the edge that samples waitrequest low
	logic access;
	logic wr_go;
	assign access = (avs_read_i || avs_write_i) && !acc_done_r;
	assign wr_go  = avs_write_i && acc_done_r;
	assign cmd    = avs_writedata_i[CMD_LSB +: CMD_W];
	assign cmd_we = wr_go && avs_address_i == ADDR_STATE_CMD;
	assign buf_we = wr_go && is_buf(avs_address_i);

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			acc_done_r <= 1'b0;
		else if (clk_en_i)
			acc_done_r <= access;
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			avs_waitrequest_o <= 1'b1;
		else if (clk_en_i)
			avs_waitrequest_o <= !access;
	end

	// mode register; frame buffer octet 0 is the length field
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			mode_r <= MODE_RST;
		else if (clk_en_i && wr_go && avs_address_i == ADDR_MODE)
			mode_r <= avs_writedata_i[2:0];
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			len_r <= 8'h00;
		else if (clk_en_i && buf_we && avs_address_i[BUF_AW-1:0] == '0)
			len_r <= {1'b0, avs_writedata_i[6:0]};
	end

	// radio state: synth-on must precede tx start
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			state_r <= RADIO_OFF;
		else if (clk_en_i)
		begin
			if (!test_en && emitting)
				state_r <= SYNTH_ON;
			else if (cmd_we)
			begin
				unique case (state_r)
					RADIO_OFF:
						if (cmd == CMD_SYNTH_ON)
							state_r <= SYNTH_ON;
					SYNTH_ON:
						if (cmd == CMD_TX_START && test_en)
							state_r <= EMITTING;
						else if (cmd == CMD_RADIO_OFF)
							state_r <= RADIO_OFF;
					EMITTING:
						if (cmd == CMD_RADIO_OFF)
							state_r <= RADIO_OFF;
						else if (cmd == CMD_SYNTH_ON)
							state_r <= SYNTH_ON;
				endcase
			end
		end
	end

	// read data
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			rdata_r <= 32'h0000_0000;
		else if (clk_en_i && access && avs_read_i)
		begin
			if (avs_address_i == ADDR_MODE)
				rdata_r <= {29'h0, mode_r};
			else if (avs_address_i == ADDR_STATE_CMD ||
				avs_address_i == ADDR_STATUS)
				rdata_r <= {26'h0, test_en,
					emitting ? ST_CODE_TX :
					(state_r == SYNTH_ON) ? ST_CODE_SYNTH : ST_CODE_OFF};
			else if (avs_address_i == ADDR_BUF_BASE)
				rdata_r <= {24'h0, len_r};
			else
				rdata_r <= 32'h0000_0000;
		end
	end
	assign avs_readdata_o = rdata_r;

	// payload fetch: octets 1..len, wrapping to 1
	// a pending octet the fifo refused blocks the next fetch, never drops
	assign fetch = clk_en_i && emitting && pseudo_sel && !buf_we &&
		(!rd_pend_r || fifo_in_ready) && len_r != 8'h00;

	frame_mem u_mem (
		.mclk_i  (mclk_i),
		.we_i    (clk_en_i && buf_we),
		.waddr_i (avs_address_i[BUF_AW-1:0]),
		.wdata_i (avs_writedata_i[7:0]),
		.re_i    (fetch),
		.raddr_i (rd_idx_r),
		.rdata_o (rd_data)
	);

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || !emitting)
			rd_idx_r <= BUF_AW'(1);
		else if (fetch)
			rd_idx_r <= ({1'b0, rd_idx_r} >= len_r) ?
				BUF_AW'(1) : rd_idx_r + 1'b1;
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || !emitting)
			rd_pend_r <= 1'b0;
		else if (clk_en_i)
			rd_pend_r <= fetch || (rd_pend_r && !fifo_in_ready);
	end

	// fifo stalls the fetch when the modulator holds ready low
	octet_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.mclk_i      (mclk_i),
		.sys_rst_i   (sys_rst_i),
		.clk_en_i    (clk_en_i),
		.flush_i     (!emitting || !pseudo_sel),
		.in_valid_i  (rd_pend_r),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (rd_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (!out_valid_r || tx_ready_i),
		.out_data_o  (fifo_out_data)
	);

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || !emitting || !pseudo_sel)
		begin
			out_valid_r <= 1'b0;
			out_octet_r <= 8'h00;
		end
		else if (clk_en_i && (!out_valid_r || tx_ready_i))
		begin
			out_valid_r <= fifo_out_valid;
			out_octet_r <= fifo_out_data;
		end
	end
	assign tx_valid_o = out_valid_r;
	assign tx_octet_o = out_octet_r;

	// rf control: centre for pseudo data, offsets only for tone
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			rf_r <= '0;
		else if (clk_en_i)
		begin
			rf_r.carrier_on <= emitting;
			rf_r.tone_on    <= emitting && !pseudo_sel;
			rf_r.offset_khz <= pseudo_sel ? 12'sd0 :
				tone_ofs(mode_r[TONE_SEL_LSB +: 2]);
		end
	end
	assign rf_ctrl_o = rf_r;

	property p_no_centre_tone;
		@(posedge mclk_i) disable iff (sys_rst_i)
		rf_r.tone_on |-> rf_r.offset_khz != 12'sd0;
	endproperty
	a_no_centre_tone: assert property (p_no_centre_tone)
		else $error("tone on centre frequency");

	property p_tone_set;
		@(posedge mclk_i) disable iff (sys_rst_i)
		rf_r.tone_on |-> (rf_r.offset_khz == OFS_MINUS_2M ||
			rf_r.offset_khz == OFS_PLUS_HALF ||
			rf_r.offset_khz == OFS_MINUS_HALF);
	endproperty
	a_tone_set: assert property (p_tone_set)
		else $error("tone offset outside set");

	property p_emit_needs_pin;
		@(posedge mclk_i) disable iff (sys_rst_i)
		clk_en_i && !test_en |=> !emitting;
	endproperty
	a_emit_needs_pin: assert property (p_emit_needs_pin)
		else $error("emitting with test pin low");

	property p_start_seq;
		@(posedge mclk_i) disable iff (sys_rst_i)
		$rose(emitting) |-> $past(state_r) == SYNTH_ON;
	endproperty
	a_start_seq: assert property (p_start_seq)
		else $error("emission without synth on");

	property p_skip_header;
		@(posedge mclk_i) disable iff (sys_rst_i)
		fetch |-> rd_idx_r != '0;
	endproperty
	a_skip_header: assert property (p_skip_header)
		else $error("length field sent as payload");

	property p_wrap;
		@(posedge mclk_i) disable iff (sys_rst_i)
		fetch && {1'b0, rd_idx_r} >= len_r ##1 emitting |->
			rd_idx_r == BUF_AW'(1);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("no wrap to first octet");

	property p_centre_pseudo;
		@(posedge mclk_i) disable iff (sys_rst_i)
		clk_en_i && emitting && pseudo_sel |=> rf_r.offset_khz == 12'sd0;
	endproperty
	a_centre_pseudo: assert property (p_centre_pseudo)
		else $error("pseudo data off centre");

	property p_carrier;
		@(posedge mclk_i) disable iff (sys_rst_i)
		clk_en_i && emitting |=> rf_r.carrier_on;
	endproperty
	a_carrier: assert property (p_carrier)
		else $error("carrier off while emitting");

endmodule

// File: test/octet_sink.sv
/*
 * Modulator-side sink model: takes octets over valid/ready and logs them.
 * Assumes the bench drives stall_i just after rising edges.
 */
module octet_sink
(
	// clock
	input  wire logic       mclk_i,
	// stream from the block
	input  wire logic [7:0] tx_octet_i,
	input  wire logic       tx_valid_i,
	output logic            tx_ready_o,
	// bench control
	input  wire logic       stall_i
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] got [$];

	initial tx_ready_o = 1'b0;

	// ready trails stall by one edge, as a registered sink would
	always @(posedge mclk_i)
	begin
		tx_ready_o <= !stall_i;
		if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1)
			got.push_back(tx_octet_i);
	end
endmodule

// File: test/cont_tx_test_tb.sv
/*
 * Bench for the continuous transmit test block: Avalon-MM host tasks,
 * one task per scenario, verdict in finish_test.
 * Assumes the octet sink model on the modulator side.
 */
`define CHK(nm, exp, got) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
		end \
	end

module cont_tx_test_tb
	import cont_tx_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        mclk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        pin = 1'b0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [7:0]  avs_addr = 8'h00;
	logic [31:0] avs_wdata = 32'h0;
	logic [31:0] rdata;
	logic        waitreq;
	logic [7:0]  octet;
	logic        valid;
	logic        ready;
	logic        stall = 1'b0;
	logic        clk_en = 1'b1;
	rf_ctrl_s    rf;
	int          fail_count = 0;
	int          cmp_count = 0;
	logic [7:0]  pay [3] = '{8'hA5, 8'h3C, 8'hF0};

	initial
	begin
		forever #2 mclk_i = ~mclk_i;
	end

	cont_tx_test DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en), .test_mode_pin_i(pin), .avs_address_i(avs_addr),
		.avs_read_i(avs_read), .avs_write_i(avs_write),
		.avs_writedata_i(avs_wdata), .avs_readdata_o(rdata),
		.avs_waitrequest_o(waitreq), .tx_octet_o(octet), .tx_valid_o(valid),
		.tx_ready_i(ready), .rf_ctrl_o(rf));

	octet_sink sink (.mclk_i(mclk_i), .tx_octet_i(octet),
		.tx_valid_i(valid), .tx_ready_o(ready), .stall_i(stall));

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic timed_out(input string what);
		fail_count++;
		$display("MISMATCH %s exp done got timeout", what);
		finish_test();
	endtask

	// request held until waitrequest is sampled low, then one idle edge
	task automatic bus_xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		avs_addr <= a;
		avs_wdata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do
		begin
			@(posedge mclk_i);
			n++;
		end
		while (waitreq !== 1'b0 && n < 50);
		if (n >= 50)
			timed_out("bus");
		q = rdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus_xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus_xfer(1'b0, a, 32'h0, q);
	endtask

	task automatic pin_set(input logic v);
		logic [31:0] q;
		int n;
		pin <= v;
		n = 0;
		do
		begin
			rd(ADDR_STATUS, q);
			n++;
		end
		while (q[5] !== v && n < 20);
		`CHK("pin sync", v, q[5]);
	endtask

	// short frame keeps the run brief; length field always valid
	task automatic host_setup(input logic [2:0] mode);
		wr(ADDR_STATE_CMD, 32'(CMD_RADIO_OFF));
		wr(ADDR_BUF_BASE, 32'h3);
		for (int i = 0; i < 3; i++)
			wr(ADDR_BUF_BASE + 8'(i + 1), 32'(pay[i]));
		wr(ADDR_MODE, {29'h0, mode});
	endtask

	task automatic start_tx();
		pin_set(1'b1);
		wr(ADDR_STATE_CMD, 32'(CMD_SYNTH_ON));
		wr(ADDR_STATE_CMD, 32'(CMD_TX_START));
	endtask

	task automatic t_reset();
		logic [31:0] q;
		`CHK("valid rst", 1'b0, valid);
		rd(ADDR_STATUS, q);
		`CHK("state rst", ST_CODE_OFF, q[4:0]);
		rd(ADDR_MODE, q);
		`CHK("mode rst", {29'h0, MODE_RST}, q);
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40, q);
		`CHK("unmapped", 32'h0, q);
	endtask

	task automatic t_no_start();
		logic [31:0] q;
		host_setup(3'h0);
		pin_set(1'b1);
		wr(ADDR_STATE_CMD, 32'(CMD_TX_START));
		repeat (20) @(posedge mclk_i);
		rd(ADDR_STATUS, q);
		`CHK("start no synth", ST_CODE_OFF, q[4:0]);
		`CHK("valid no synth", 1'b0, valid);
		pin_set(1'b0);
		wr(ADDR_STATE_CMD, 32'(CMD_SYNTH_ON));
		wr(ADDR_STATE_CMD, 32'(CMD_TX_START));
		repeat (20) @(posedge mclk_i);
		rd(ADDR_STATUS, q);
		`CHK("start pin low", ST_CODE_SYNTH, q[4:0]);
		`CHK("valid pin low", 1'b0, valid);
	endtask

	task automatic t_pseudo();
		logic [31:0] q;
		int n;
		int bad;
		logic [7:0] o;
		host_setup(3'h0);
		stall <= 1'b1;
		start_tx();
		for (n = 0; n < 50 && valid !== 1'b1; n++)
			@(posedge mclk_i);
		if (n >= 50)
			timed_out("first octet");
		bad = 0;
		// modulator stalls: first payload octet must stand
		repeat (30)
		begin
			@(posedge mclk_i);
			if (valid !== 1'b1 || octet !== pay[0])
				bad++;
		end
		`CHK("stall hold", 0, bad);
		`CHK("carrier", 1'b1, rf.carrier_on);
		`CHK("no tone", 1'b0, rf.tone_on);
		`CHK("centre", 12'sd0, rf.offset_khz);
		sink.got.delete();
		stall <= 1'b0;
		for (n = 0; n < 300 && sink.got.size() < 12; n++)
			@(posedge mclk_i);
		if (n >= 300)
			timed_out("stream");
		for (int i = 0; i < 12; i++)
			`CHK("octet", pay[i % 3], sink.got[i]);
		bad = 0;
		repeat (20)
		begin
			@(posedge mclk_i);
			if (valid !== 1'b1)
				bad++;
		end
		`CHK("gapless", 0, bad);
		// enable low: octet and valid must freeze
		clk_en <= 1'b0;
		@(posedge mclk_i);
		o = octet;
		bad = 0;
		repeat (10)
		begin
			@(posedge mclk_i);
			if (valid !== 1'b1 || octet !== o)
				bad++;
		end
		clk_en <= 1'b1;
		`CHK("frozen", 0, bad);
		pin_set(1'b0);
		for (n = 0; n < 20 && valid !== 1'b0; n++)
			@(posedge mclk_i);
		`CHK("stop valid", 1'b0, valid);
		rd(ADDR_STATUS, q);
		`CHK("stop state", ST_CODE_SYNTH, q[4:0]);
	endtask

	task automatic t_tone();
		logic signed [11:0] ofs [4];
		logic [31:0] q;
		ofs = '{OFS_MINUS_2M, OFS_PLUS_HALF, OFS_MINUS_HALF, OFS_MINUS_HALF};
		for (int k = 0; k < 4; k++)
		begin
			host_setup({2'(k), 1'b1});
			start_tx();
			repeat (10) @(posedge mclk_i);
			`CHK("tone on", 1'b1, rf.tone_on);
			`CHK("offset", ofs[k], rf.offset_khz);
			`CHK("off centre", 1'b1, rf.offset_khz != 12'sd0);
			`CHK("tone no data", 1'b0, valid);
			if (k == 3)
			begin
				wr(ADDR_STATE_CMD, 32'(CMD_RADIO_OFF));
				rd(ADDR_STATUS, q);
				`CHK("cmd off", ST_CODE_OFF, q[4:0]);
				`CHK("tone off", 1'b0, rf.tone_on);
			end
			pin_set(1'b0);
		end
	endtask

	initial
	begin
		repeat (20) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		@(posedge mclk_i);
		t_reset();
		t_no_start();
		t_pseudo();
		t_tone();
		finish_test();
	end
endmodule
